/* File: src/cpuexe_cfg.svh */
`ifndef CPUEXE_CFG_SVH
`define CPUEXE_CFG_SVH

// opcodes
`define CPUEXE_OP_NEXT     8'h0f
`define CPUEXE_OP_OR_RR    8'h42
`define CPUEXE_OP_OR_RI    8'h43
`define CPUEXE_OP_OR_GG    8'h44
`define CPUEXE_OP_OR_GI    8'h45
`define CPUEXE_OP_OR_IM    8'h46
`define CPUEXE_OP_MUL_R    8'h84
`define CPUEXE_OP_MUL_I    8'h85
`define CPUEXE_OP_MUL_IM   8'h86
`define CPUEXE_OP_LDW_RR   8'hc4
`define CPUEXE_OP_LDW_IR   8'hc5
`define CPUEXE_OP_LDW_IML  8'hc6
`define CPUEXE_OP_ST_DEC   8'hf2
`define CPUEXE_OP_ST_INC   8'hf3
`define CPUEXE_OP_NOP      8'hff

// cycle counts per instruction
`define CPUEXE_CYC_NEXT    5'h0a
`define CPUEXE_CYC_OR_RR   5'h04
`define CPUEXE_CYC_OR      5'h06
`define CPUEXE_CYC_MUL     5'h16
`define CPUEXE_CYC_LDW     5'h08
`define CPUEXE_CYC_ST      5'h0e
`define CPUEXE_CYC_NOP     5'h04

// flag bit positions
`define CPUEXE_FLG_C       7
`define CPUEXE_FLG_Z       6
`define CPUEXE_FLG_S       5
`define CPUEXE_FLG_V       4
`define CPUEXE_FLG_D       3
`define CPUEXE_FLG_H       2

// product limit for carry
`define CPUEXE_MUL_LIMIT   16'h00ff

// pointer increments
`define CPUEXE_PAIR_STEP   16'h0001
`define CPUEXE_IP_STEP     16'h0002

// register port offsets
`define CPUEXE_REG_CTRL    3'h0
`define CPUEXE_REG_STATUS  3'h1
`define CPUEXE_REG_FLAGS   3'h2
`define CPUEXE_REG_IPH     3'h3
`define CPUEXE_REG_IPL     3'h4
`define CPUEXE_REG_LASTOP  3'h5

// field positions
`define CPUEXE_CTRL_RUN    0
`define CPUEXE_ST_BUSY     0
`define CPUEXE_ST_PAIRERR  1
`define CPUEXE_ST_BADOP    2

// reset values
`define CPUEXE_RST_CTRL    8'h01
`define CPUEXE_RST_FLAGS   8'h00
`define CPUEXE_RST_IP      16'h0000

`endif

/* File: src/cpuexe_pkg.sv */
package cpuexe_pkg;

    typedef enum logic [2:0] {
        CPUEXE_S_IDLE = 3'b000,
        CPUEXE_S_PTR  = 3'b001,
        CPUEXE_S_OPR  = 3'b010,
        CPUEXE_S_CAP  = 3'b011,
        CPUEXE_S_WR0  = 3'b100,
        CPUEXE_S_WR1  = 3'b101,
        CPUEXE_S_WAIT = 3'b110
    } cpuexe_state_t;

    typedef struct packed {
        logic [7:0] opc;
        logic [7:0] b1;
        logic [7:0] b2;
        logic [7:0] b3;
    } cpuexe_ins_t;

    typedef struct packed {
        logic       we;
        logic [7:0] addr;
        logic [7:0] data;
    } cpuexe_rfw_t;

    typedef struct packed {
        logic        req;
        logic        we;
        logic        code;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } cpuexe_mem_t;

endpackage : cpuexe_pkg

/* File: src/cpuexe_alu.sv */
`timescale 1ns/100ps
`include "cpuexe_cfg.svh"

module cpuexe_alu (
    input  wire logic [7:0]  va,
    input  wire logic [7:0]  vb,
    input  wire logic [7:0]  flags_in,
    output logic      [7:0]  or_res,
    output logic      [15:0] prod,
    output logic      [7:0]  or_flags,
    output logic      [7:0]  mul_flags
);
    always_comb begin
        or_res = vb | va;
        prod   = {8'h00, vb} * {8'h00, va};
    end

    always_comb begin
        or_flags                  = flags_in;
        or_flags[`CPUEXE_FLG_Z]   = (or_res == 8'h00);
        or_flags[`CPUEXE_FLG_S]   = or_res[7];
        or_flags[`CPUEXE_FLG_V]   = 1'b0;
        mul_flags                 = flags_in;
        mul_flags[`CPUEXE_FLG_C]  = (prod > `CPUEXE_MUL_LIMIT);
        mul_flags[`CPUEXE_FLG_Z]  = (prod == 16'h0000);
        mul_flags[`CPUEXE_FLG_S]  = prod[15];
        mul_flags[`CPUEXE_FLG_V]  = 1'b0;
    end
endmodule : cpuexe_alu

/* File: src/cpuexe_timer.sv */
`timescale 1ns/100ps

module cpuexe_timer (
    input  wire logic       mclk,
    input  wire logic       reset,
    input  wire logic       load,
    input  wire logic [4:0] load_val,
    output logic            last
);
    logic [4:0] cnt_q;

    // loaded with count-1 so the last busy cycle sees one
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cnt_q <= 5'h00;
        end else if (load) begin
            cnt_q <= load_val - 5'h01;
        end else if (cnt_q != 5'h00) begin
            cnt_q <= cnt_q - 5'h01;
        end
    end

    assign last = (cnt_q == 5'h01);
endmodule : cpuexe_timer

/* File: src/cpuexe_core.sv */
`timescale 1ns/100ps
`include "cpuexe_cfg.svh"

module cpuexe_core (
    input  wire logic                    mclk,
    input  wire logic                    reset,
    input  wire logic                    ins_valid,
    input  wire cpuexe_pkg::cpuexe_ins_t ins_data,
    output logic                         ins_ready,
    input  wire logic [3:0]              wrk_base,
    output logic [7:0]                   rf_a_addr,
    output logic [7:0]                   rf_b_addr,
    input  wire logic [7:0]              rf_a_rdata,
    input  wire logic [7:0]              rf_b_rdata,
    output cpuexe_pkg::cpuexe_rfw_t      rf_wr,
    output cpuexe_pkg::cpuexe_mem_t      mem_out,
    input  wire logic [7:0]              mem_rdata,
    output logic                         pc_load,
    output logic [15:0]                  pc_value,
    output logic [7:0]                   flags,
    input  wire logic [2:0]              reg_addr,
    input  wire logic [7:0]              reg_wdata,
    input  wire logic                    reg_we,
    input  wire logic                    reg_re,
    output logic [7:0]                   reg_rdata
);
    import cpuexe_pkg::*;

    cpuexe_state_t state_q;
    cpuexe_state_t state_d;
    cpuexe_ins_t   ins_q;
    cpuexe_rfw_t   rf_wr_q;
    cpuexe_rfw_t   wr1_q;
    cpuexe_mem_t   mem_q;
    logic [7:0]    flags_q;
    logic [15:0]   ip_q;
    logic [7:0]    srcv_q;
    logic [7:0]    pchi_q;
    logic          pc_load_q;
    logic [15:0]   pc_value_q;
    logic [7:0]    ctrl_q;
    logic          pairerr_q;
    logic          badop_q;
    logic [7:0]    lastop_q;
    logic [7:0]    reg_rdata_q;

    logic          fire;
    logic          last;
    logic [4:0]    cyc;
    logic          is_or, is_mul, is_ldw, is_st, is_nx, is_known;
    logic          indir, use_ptr, imm, two_wr, pair0;
    logic [7:0]    ptr_addr, src_direct, dst_b, wdst_e, immv;
    logic [7:0]    va, vb;
    logic [15:0]   pair, npair;
    logic [7:0]    or_res, or_flags, mul_flags;
    logic [15:0]   prod;
    logic [3:0]    hn_in, hn, ln;

    // instruction classes of the latched opcode
    always_comb begin
        hn       = ins_q.b1[7:4];
        ln       = ins_q.b1[3:0];
        is_or    = (ins_q.opc >= `CPUEXE_OP_OR_RR) && (ins_q.opc <= `CPUEXE_OP_OR_IM);
        is_mul   = (ins_q.opc >= `CPUEXE_OP_MUL_R) && (ins_q.opc <= `CPUEXE_OP_MUL_IM);
        is_ldw   = (ins_q.opc >= `CPUEXE_OP_LDW_RR) && (ins_q.opc <= `CPUEXE_OP_LDW_IML);
        is_st    = (ins_q.opc == `CPUEXE_OP_ST_DEC) || (ins_q.opc == `CPUEXE_OP_ST_INC);
        is_nx    = (ins_q.opc == `CPUEXE_OP_NEXT);
        indir    = (ins_q.opc == `CPUEXE_OP_OR_RI) || (ins_q.opc == `CPUEXE_OP_OR_GI) ||
                   (ins_q.opc == `CPUEXE_OP_MUL_I) || (ins_q.opc == `CPUEXE_OP_LDW_IR);
        use_ptr  = indir || is_st || is_nx;
        imm      = (ins_q.opc == `CPUEXE_OP_OR_IM) || (ins_q.opc == `CPUEXE_OP_MUL_IM);
        immv     = (ins_q.opc == `CPUEXE_OP_OR_IM) ? ins_q.b2 : ins_q.b1;
        two_wr   = is_mul || is_ldw || is_st;
    end

    // register addresses of each operand
    always_comb begin
        ptr_addr   = ins_q.b1;
        src_direct = ins_q.b1;
        dst_b      = ins_q.b2;
        wdst_e     = {ins_q.b2[7:1], 1'b0};
        if (ins_q.opc == `CPUEXE_OP_OR_RR || ins_q.opc == `CPUEXE_OP_OR_RI) begin
            ptr_addr   = {wrk_base, ln};
            src_direct = {wrk_base, ln};
            dst_b      = {wrk_base, hn};
            wdst_e     = {wrk_base, hn};
        end else if (ins_q.opc == `CPUEXE_OP_OR_IM) begin
            dst_b      = ins_q.b1;
            wdst_e     = ins_q.b1;
        end else if (is_or) begin
            wdst_e     = ins_q.b2;
        end else if (is_mul) begin
            dst_b      = {ins_q.b2[7:1], 1'b0};
        end else if (ins_q.opc == `CPUEXE_OP_LDW_RR) begin
            src_direct = {ins_q.b1[7:1], 1'b0};
            dst_b      = {ins_q.b1[7:1], 1'b1};
        end else if (ins_q.opc == `CPUEXE_OP_LDW_IML) begin
            wdst_e     = {ins_q.b1[7:1], 1'b0};
        end else if (is_st) begin
            ptr_addr   = {wrk_base, ln};
            src_direct = {wrk_base, hn[3:1], 1'b0};
            dst_b      = {wrk_base, hn[3:1], 1'b1};
            wdst_e     = {wrk_base, hn[3:1], 1'b0};
        end
    end

    // cycle count, decoded from the arriving opcode
    always_comb begin
        hn_in = ins_data.b1[7:4];
        pair0 = 1'b0;
        case (ins_data.opc)
            `CPUEXE_OP_NEXT:     cyc = `CPUEXE_CYC_NEXT;
            `CPUEXE_OP_OR_RR:    cyc = `CPUEXE_CYC_OR_RR;
            `CPUEXE_OP_OR_RI,
            `CPUEXE_OP_OR_GG,
            `CPUEXE_OP_OR_GI,
            `CPUEXE_OP_OR_IM:    cyc = `CPUEXE_CYC_OR;
            `CPUEXE_OP_MUL_R,
            `CPUEXE_OP_MUL_I,
            `CPUEXE_OP_MUL_IM:   cyc = `CPUEXE_CYC_MUL;
            `CPUEXE_OP_LDW_RR,
            `CPUEXE_OP_LDW_IR,
            `CPUEXE_OP_LDW_IML:  cyc = `CPUEXE_CYC_LDW;
            `CPUEXE_OP_ST_DEC,
            `CPUEXE_OP_ST_INC: begin
                cyc   = `CPUEXE_CYC_ST;
                pair0 = (hn_in[3:1] == 3'b000);
            end
            default:             cyc = `CPUEXE_CYC_NOP;
        endcase
        is_known = (cyc != `CPUEXE_CYC_NOP) || (ins_data.opc == `CPUEXE_OP_NOP) ||
                   (ins_data.opc == `CPUEXE_OP_OR_RR);
    end

    assign ins_ready = (state_q == CPUEXE_S_IDLE) && ctrl_q[`CPUEXE_CTRL_RUN];
    assign fire      = ins_valid && ins_ready;

    cpuexe_timer u_timer (
        .mclk     (mclk),
        .reset    (reset),
        .load     (fire),
        .load_val (cyc),
        .last     (last)
    );

    // operand values and results in the capture cycle
    always_comb begin
        va    = imm ? immv : rf_a_rdata;
        vb    = rf_b_rdata;
        pair  = {va, vb};
        npair = (ins_q.opc == `CPUEXE_OP_ST_DEC) ? pair - `CPUEXE_PAIR_STEP : pair + `CPUEXE_PAIR_STEP;
    end

    cpuexe_alu u_alu (
        .va        (va),
        .vb        (vb),
        .flags_in  (flags_q),
        .or_res    (or_res),
        .prod      (prod),
        .or_flags  (or_flags),
        .mul_flags (mul_flags)
    );

    always_comb begin
        state_d = state_q;
        case (state_q)
            CPUEXE_S_IDLE: begin
                if (fire) begin
                    if (!is_known || pair0 || ins_data.opc == `CPUEXE_OP_NOP) begin
                        state_d = CPUEXE_S_WAIT;
                    end else if (ins_data.opc == `CPUEXE_OP_NEXT || ins_data.opc == `CPUEXE_OP_OR_RI ||
                                 ins_data.opc == `CPUEXE_OP_OR_GI || ins_data.opc == `CPUEXE_OP_MUL_I ||
                                 ins_data.opc == `CPUEXE_OP_LDW_IR || ins_data.opc == `CPUEXE_OP_ST_DEC ||
                                 ins_data.opc == `CPUEXE_OP_ST_INC) begin
                        state_d = CPUEXE_S_PTR;
                    end else begin
                        state_d = CPUEXE_S_OPR;
                    end
                end
            end
            CPUEXE_S_PTR:  state_d = CPUEXE_S_OPR;
            CPUEXE_S_OPR:  state_d = CPUEXE_S_CAP;
            CPUEXE_S_CAP: begin
                if (is_nx) begin
                    state_d = last ? CPUEXE_S_IDLE : CPUEXE_S_WAIT;
                end else begin
                    state_d = CPUEXE_S_WR0;
                end
            end
            CPUEXE_S_WR0: begin
                if (two_wr) begin
                    state_d = CPUEXE_S_WR1;
                end else begin
                    state_d = last ? CPUEXE_S_IDLE : CPUEXE_S_WAIT;
                end
            end
            CPUEXE_S_WR1:  state_d = last ? CPUEXE_S_IDLE : CPUEXE_S_WAIT;
            CPUEXE_S_WAIT: state_d = last ? CPUEXE_S_IDLE : CPUEXE_S_WAIT;
            default:       state_d = CPUEXE_S_IDLE;
        endcase
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_q <= CPUEXE_S_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ins_q <= '0;
        end else if (fire) begin
            ins_q <= ins_data;
        end
    end

    // read addresses; port b is unused outside the operand cycle
    always_comb begin
        rf_a_addr = 8'h00;
        rf_b_addr = 8'h00;
        if (state_q == CPUEXE_S_PTR) begin
            rf_a_addr = ptr_addr;
        end else if (state_q == CPUEXE_S_OPR) begin
            rf_a_addr = indir ? rf_a_rdata : src_direct;
            rf_b_addr = dst_b;
            if (ins_q.opc == `CPUEXE_OP_LDW_IR) begin
                rf_b_addr = rf_a_rdata + 8'h01;
            end
        end
    end

    // store source byte is read ahead of the pair
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            srcv_q <= 8'h00;
        end else if (state_q == CPUEXE_S_OPR) begin
            srcv_q <= rf_a_rdata;
        end
    end

    // register file writes, second byte parked until the first is out
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rf_wr_q <= '0;
            wr1_q   <= '0;
        end else begin
            rf_wr_q.we <= 1'b0;
            if (state_q == CPUEXE_S_CAP) begin
                if (is_or) begin
                    rf_wr_q <= '{we: 1'b1, addr: wdst_e, data: or_res};
                end else if (is_mul) begin
                    rf_wr_q <= '{we: 1'b1, addr: dst_b, data: prod[15:8]};
                    wr1_q   <= '{we: 1'b1, addr: {dst_b[7:1], 1'b1}, data: prod[7:0]};
                end else if (ins_q.opc == `CPUEXE_OP_LDW_IML) begin
                    rf_wr_q <= '{we: 1'b1, addr: wdst_e, data: ins_q.b2};
                    wr1_q   <= '{we: 1'b1, addr: {wdst_e[7:1], 1'b1}, data: ins_q.b3};
                end else if (is_ldw) begin
                    rf_wr_q <= '{we: 1'b1, addr: wdst_e, data: va};
                    wr1_q   <= '{we: 1'b1, addr: {wdst_e[7:1], 1'b1}, data: vb};
                end else if (is_st) begin
                    rf_wr_q <= '{we: 1'b1, addr: wdst_e, data: npair[15:8]};
                    wr1_q   <= '{we: 1'b1, addr: {wdst_e[7:1], 1'b1}, data: npair[7:0]};
                end
            end else if (state_q == CPUEXE_S_WR0 && two_wr) begin
                rf_wr_q <= wr1_q;
            end
        end
    end

    // memory port: thread fetch reads and pre-modified stores
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            mem_q <= '0;
        end else begin
            mem_q <= '0;
            if (fire && ins_data.opc == `CPUEXE_OP_NEXT) begin
                mem_q <= '{req: 1'b1, we: 1'b0, code: 1'b1, addr: ip_q, wdata: 8'h00};
            end else if (state_q == CPUEXE_S_PTR && is_nx) begin
                mem_q <= '{req: 1'b1, we: 1'b0, code: 1'b1, addr: ip_q + `CPUEXE_PAIR_STEP, wdata: 8'h00};
            end else if (state_q == CPUEXE_S_CAP && is_st) begin
                // address is the updated pair, never the old one
                mem_q <= '{req: 1'b1, we: 1'b1, code: ~hn[0], addr: npair, wdata: srcv_q};
            end
        end
    end

    // program counter load for thread dispatch, on the same edge as the pointer bump
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pchi_q     <= 8'h00;
            pc_load_q  <= 1'b0;
            pc_value_q <= 16'h0000;
        end else begin
            pc_load_q <= 1'b0;
            if (state_q == CPUEXE_S_OPR && is_nx) begin
                pchi_q <= mem_rdata;
            end
            if (state_q == CPUEXE_S_CAP && is_nx) begin
                pc_load_q  <= 1'b1;
                pc_value_q <= {pchi_q, mem_rdata};
            end
        end
    end

    // thread pointer: hardware bump wins over a software write
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ip_q <= `CPUEXE_RST_IP;
        end else if (state_q == CPUEXE_S_CAP && is_nx) begin
            ip_q <= ip_q + `CPUEXE_IP_STEP;
        end else if (reg_we && reg_addr == `CPUEXE_REG_IPH) begin
            ip_q[15:8] <= reg_wdata;
        end else if (reg_we && reg_addr == `CPUEXE_REG_IPL) begin
            ip_q[7:0] <= reg_wdata;
        end
    end

    // flags: only OR, multiply and a software write to the flags register touch them
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            flags_q <= `CPUEXE_RST_FLAGS;
        end else if (state_q == CPUEXE_S_CAP && is_or) begin
            flags_q <= or_flags;
        end else if (state_q == CPUEXE_S_CAP && is_mul) begin
            flags_q <= mul_flags;
        end else if (reg_we && reg_addr == `CPUEXE_REG_FLAGS) begin
            flags_q <= reg_wdata;
        end
    end

    // control and sticky status; a new event beats a clear
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ctrl_q    <= `CPUEXE_RST_CTRL;
            pairerr_q <= 1'b0;
            badop_q   <= 1'b0;
            lastop_q  <= 8'h00;
        end else begin
            if (reg_we && reg_addr == `CPUEXE_REG_CTRL) begin
                ctrl_q <= reg_wdata;
            end
            if (fire && pair0) begin
                pairerr_q <= 1'b1;
            end else if (reg_we && reg_addr == `CPUEXE_REG_STATUS && reg_wdata[`CPUEXE_ST_PAIRERR]) begin
                pairerr_q <= 1'b0;
            end
            if (fire && !is_known) begin
                badop_q <= 1'b1;
            end else if (reg_we && reg_addr == `CPUEXE_REG_STATUS && reg_wdata[`CPUEXE_ST_BADOP]) begin
                badop_q <= 1'b0;
            end
            if (fire) begin
                lastop_q <= ins_data.opc;
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            reg_rdata_q <= 8'h00;
        end else if (reg_re) begin
            if (reg_addr == `CPUEXE_REG_CTRL) begin
                reg_rdata_q <= ctrl_q;
            end else if (reg_addr == `CPUEXE_REG_STATUS) begin
                reg_rdata_q <= {5'h00, badop_q, pairerr_q, (state_q != CPUEXE_S_IDLE)};
            end else if (reg_addr == `CPUEXE_REG_FLAGS) begin
                reg_rdata_q <= flags_q;
            end else if (reg_addr == `CPUEXE_REG_IPH) begin
                reg_rdata_q <= ip_q[15:8];
            end else if (reg_addr == `CPUEXE_REG_IPL) begin
                reg_rdata_q <= ip_q[7:0];
            end else if (reg_addr == `CPUEXE_REG_LASTOP) begin
                reg_rdata_q <= lastop_q;
            end else begin
                reg_rdata_q <= 8'h00;
            end
        end else begin
            reg_rdata_q <= 8'h00;
        end
    end

    assign rf_wr     = rf_wr_q;
    assign mem_out   = mem_q;
    assign pc_load   = pc_load_q;
    assign pc_value  = pc_value_q;
    assign flags     = flags_q;
    assign reg_rdata = reg_rdata_q;
endmodule : cpuexe_core

/* File: verif/cpuexe_far_model.sv */
`timescale 1ns/100ps
module cpuexe_far_model (
    input  wire cpuexe_pkg::cpuexe_rfw_t rf_wr,
    input  wire cpuexe_pkg::cpuexe_mem_t mem_out,
    input  wire logic                    mclk,
    input  wire logic [7:0]              rf_a_addr,
    input  wire logic [7:0]              rf_b_addr,
    output logic      [7:0]              rf_a_rdata,
    output logic      [7:0]              rf_b_rdata,
    output logic      [7:0]              mem_rdata
);
    import cpuexe_pkg::*;
    logic [7:0] rf [256];
    logic [7:0] mem [2][65536];
    initial mem_rdata = 8'h5a;
    always @(posedge mclk) begin
        rf_a_rdata <= rf[rf_a_addr];
        rf_b_rdata <= rf[rf_b_addr];
        if (rf_wr.we)
            rf[rf_wr.addr] <= rf_wr.data;
    end
    // idle bus toggles so a stale byte is never mistaken for data
    always @(posedge mclk) begin
        if (mem_out.req && mem_out.we)
            mem[mem_out.code][mem_out.addr] <= mem_out.wdata;
        mem_rdata <= (mem_out.req && !mem_out.we) ? mem[mem_out.code][mem_out.addr] : ~mem_rdata;
    end
endmodule : cpuexe_far_model

/* File: verif/cpuexe_core_assertions.sv */
`timescale 1ns/100ps
module cpuexe_chk (
    input wire logic                    mclk,
    input wire logic                    reset,
    input wire logic                    ins_valid,
    input wire logic                    ins_ready,
    input wire cpuexe_pkg::cpuexe_ins_t ins_data,
    input wire cpuexe_pkg::cpuexe_rfw_t rf_wr,
    input wire cpuexe_pkg::cpuexe_mem_t mem_out,
    input wire logic                    pc_load,
    input wire logic [7:0]              flags
);
    import cpuexe_pkg::*;
    logic acc;
    logic space_q;
    logic st;
    assign acc = ins_valid && ins_ready;
    assign st = acc && ins_data.opc inside {8'hf2, 8'hf3};
    // space bit is gone from ins_data by the store cycle
    always_ff @(posedge mclk or posedge reset)
        if (reset)
            space_q <= 1'b0;
        else if (acc)
            space_q <= ins_data.b1[4];
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    a_nop_quiet: assert property (acc && ins_data.opc == 8'hff |=>
        (!rf_wr.we && !mem_out.req && $stable(flags))[*3] ##1 ins_ready) else $error("nop side effect");
    a_or_time: assert property (acc && ins_data.opc == 8'h42 |-> ##3 !ins_ready ##1 ins_ready)
        else $error("or length");
    a_or_flags: assert property (acc && ins_data.opc inside {8'h42, 8'h44, 8'h46} |->
        ##4 !flags[4] && flags[7] == $past(flags[7], 4)) else $error("or flags");
    a_mul_time: assert property (acc && ins_data.opc inside {[8'h84:8'h86]} |->
        ##21 !ins_ready ##1 ins_ready) else $error("multiply length");
    a_mul_flags: assert property (acc && ins_data.opc inside {[8'h84:8'h86]} |->
        ##4 !flags[4] && flags[3:2] == $past(flags[3:2], 4)) else $error("multiply flags");
    a_ldw_keep: assert property (acc && ins_data.opc inside {[8'hc4:8'hc6]} |->
        ##7 !ins_ready ##1 ins_ready && flags == $past(flags, 8)) else $error("word copy");
    a_store_time: assert property (st |-> ##13 !ins_ready ##1 ins_ready)
        else $error("store length");
    a_store_space: assert property (st && ins_data.b1[7:5] != 3'h0 |->
        ##[1:6] mem_out.req && mem_out.we && mem_out.code == !space_q) else $error("store space");
    a_pair_zero: assert property (st && ins_data.b1[7:5] == 3'h0 |=>
        (!mem_out.req && !rf_wr.we)[*8]) else $error("pair zero used");
    a_next_load: assert property (acc && ins_data.opc == 8'h0f |-> ##3 !pc_load ##1 pc_load ##1 !pc_load)
        else $error("dispatch load");
    c_next: cover property (pc_load);
    c_store: cover property (mem_out.req && mem_out.we);
    c_mul: cover property (acc && ins_data.opc == 8'h86);
endmodule : cpuexe_chk
bind cpuexe_core cpuexe_chk u_chk (.mclk(mclk), .reset(reset), .ins_valid(ins_valid), .ins_ready(ins_ready),
    .ins_data(ins_data), .rf_wr(rf_wr), .mem_out(mem_out), .pc_load(pc_load), .flags(flags));

/* File: verif/testbench.sv */
`timescale 1ns/100ps
module testbench;
    import cpuexe_pkg::*;
    logic        mclk, reset, ins_valid, ins_ready, reg_we, reg_re, pc_load;
    logic [7:0]  rf_a_addr, rf_b_addr, rf_a_rdata, rf_b_rdata, mem_rdata, flags, reg_wdata, reg_rdata;
    logic [2:0]  reg_addr;
    logic [15:0] pc_value;
    cpuexe_ins_t ins_data;
    cpuexe_rfw_t rf_wr;
    cpuexe_mem_t mem_out;
    int          miscompares = 0;
    int          n_tests = 0;
    // op b1 b2 b3, checked pair, word, flags, cycles
    logic [71:0] rows [17] = '{
        72'h42010000_10_3f2a_8c_04, 72'h43020000_10_172a_8c_06, 72'h44010000_00_2303_8c_06,
        72'h45000100_00_208b_ac_06, 72'h46024000_02_4906_8c_06, 72'h84020000_00_0120_8c_16,
        72'h85010000_00_00c0_0c_16, 72'h86300100_00_0600_8c_16, 72'h86000000_00_0000_4c_16,
        72'hc4020000_00_0906_9c_08, 72'hc5120400_04_0309_9c_08, 72'hc6061234_06_1234_9c_08,
        72'hff000000_10_152a_9c_04, 72'hf3600000_16_3001_9c_0e, 72'hf2700000_16_2fff_9c_0e,
        72'hf2100000_16_3000_9c_0e, 72'h00000000_10_152a_9c_04};
    cpuexe_core dut (.mclk(mclk), .reset(reset), .ins_valid(ins_valid), .ins_data(ins_data),
        .ins_ready(ins_ready), .wrk_base(4'h1), .rf_a_addr(rf_a_addr), .rf_b_addr(rf_b_addr),
        .rf_a_rdata(rf_a_rdata), .rf_b_rdata(rf_b_rdata), .rf_wr(rf_wr), .mem_out(mem_out),
        .mem_rdata(mem_rdata), .pc_load(pc_load), .pc_value(pc_value), .flags(flags), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata));
    cpuexe_far_model far (.mclk(mclk), .rf_a_addr(rf_a_addr), .rf_b_addr(rf_b_addr), .rf_wr(rf_wr),
        .mem_out(mem_out), .rf_a_rdata(rf_a_rdata), .rf_b_rdata(rf_b_rdata), .mem_rdata(mem_rdata));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        repeat (5000) @(posedge mclk);
        miscompares++;
        end_of_test();
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_of_test();
        if (miscompares == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_of_test
    task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_we <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge mclk);
        reg_re <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_re <= 1'b0;
        #1;
        chk({8'h00, reg_rdata}, {8'h00, e});
    endtask : reg_rd
    // counts cycles from the accepting edge until ready returns
    task automatic run(input logic [31:0] i, input logic [7:0] n);
        int k = 0;
        @(posedge mclk);
        ins_valid <= 1'b1;
        ins_data <= i;
        @(posedge mclk);
        ins_valid <= 1'b0;
        do begin
            @(posedge mclk);
            #1;
            k++;
        end while (ins_ready !== 1'b1 && k < 40);
        chk(16'(k + 1), {8'h00, n});
    endtask : run
    task automatic preset();
        {far.rf[8'h00], far.rf[8'h01], far.rf[8'h02], far.rf[8'h03], far.rf[8'h04]} = 40'h2003_0906_0f;
        {far.rf[8'h10], far.rf[8'h11], far.rf[8'h12], far.rf[8'h16], far.rf[8'h17]} = 40'h152a_0130_00;
        far.rf[8'h20] = 8'h8a;
        reg_wr(3'h2, 8'h9c);
    endtask : preset
    initial begin
        reset = 1'b1;
        ins_valid = 1'b0;
        ins_data = '0;
        reg_we = 1'b0;
        reg_re = 1'b0;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        reg_rd(3'h0, 8'h01);
        reg_rd(3'h2, 8'h00);
        reg_rd(3'h7, 8'h00);
        foreach (rows[r]) begin
            preset();
            run(rows[r][71:40], rows[r][7:0]);
            chk({far.rf[rows[r][39:32]], far.rf[rows[r][39:32] + 8'h01]}, rows[r][31:16]);
            chk({8'h00, flags}, {8'h00, rows[r][15:8]});
        end
        chk({far.mem[1][16'h3001], far.mem[0][16'h2fff]}, 16'h1515);
        reg_rd(3'h1, 8'h06);
        reg_wr(3'h1, 8'h06);
        reg_rd(3'h1, 8'h00);
        // reset lands in the middle of a multiply
        @(posedge mclk);
        ins_valid <= 1'b1;
        ins_data <= 32'h8402_0000;
        repeat (3) @(posedge mclk);
        reset <= 1'b1;
        ins_valid <= 1'b0;
        @(posedge mclk);
        reset <= 1'b0;
        #1;
        chk({7'h00, ins_ready, flags}, 16'h0100);
        reg_rd(3'h5, 8'h00);
        reg_wr(3'h0, 8'h00);
        #1;
        chk({15'h0000, ins_ready}, 16'h0000);
        reg_wr(3'h0, 8'h01);
        reg_wr(3'h3, 8'h00);
        reg_wr(3'h4, 8'h40);
        {far.mem[1][16'h0040], far.mem[1][16'h0041]} = 16'habcd;
        run(32'h0f00_0000, 8'h0a);
        chk(pc_value, 16'habcd);
        reg_rd(3'h4, 8'h42);
        reg_rd(3'h5, 8'h0f);
        end_of_test();
    end
endmodule : testbench
